/* File: logic/gdfr_pkg.sv */
// constants and types for the gate driver fault response block
package gdfr_pkg;
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          DEG_HW_US       = 4;
    localparam int          DEG_HW_CYC      = (DEG_HW_US * CLK_HZ + 999_999) / 1_000_000;
    localparam logic [1:0]  OCM_LATCH       = 2'h0;
    localparam logic [1:0]  OCM_RETRY       = 2'h1;
    localparam logic [1:0]  OCM_REPORT      = 2'h2;
    localparam logic [1:0]  OCM_DISABLED    = 2'h3;
    localparam logic [2:0]  MODE_HALF_BR    = 3'h3;
    localparam int          MODE_FET_MIN    = 4;
    localparam logic        TSD_LATCHED     = 1'b0;
    localparam logic        TSD_AUTO        = 1'b1;
    localparam int          CNT_W           = 16;
    localparam int          RETRY_W         = 24;
    localparam int          NPH             = 3;
    localparam logic [CNT_W-1:0] DEG_HW_CNT = CNT_W'(DEG_HW_CYC);
    typedef enum logic [2:0] {
        GDFR_RUN   = 3'b001,
        GDFR_HOLD  = 3'b010,
        GDFR_RETRY = 3'b100
    } gdfr_oc_t;
endpackage

/* File: logic/gdfr_top.sv */
// fault-response core of a three half-bridge gate driver
`timescale 1ns/1ps
module gdfr_top (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       resetn,
    // variant and configuration
    input  wire logic                       hw_variant,
    input  wire logic                       drain_source_threshold_pin,
    input  wire logic [1:0]                 overcurrent_response_mode,
    input  wire logic [gdfr_pkg::CNT_W-1:0] overcurrent_deglitch_select,
    input  wire logic [gdfr_pkg::RETRY_W-1:0] retry_interval,
    input  wire logic [gdfr_pkg::CNT_W-1:0] gate_drive_window,
    input  wire logic [2:0]                 pwm_mode,
    input  wire logic [2:0]                 phase_fet_mode,
    input  wire logic [2:0]                 sense_monitor_disable_x,
    input  wire logic                       gate_fault_disable,
    input  wire logic                       thermal_warning_report,
    input  wire logic                       thermal_shutdown_mode,
    input  wire logic                       clear_faults,
    input  wire logic                       sleep_reset_pulse,
    // analog comparator inputs and gate commands
    input  wire logic [2:0]                 sense_positive_input,
    input  wire logic [5:0]                 gate_cmd,
    input  wire logic [5:0]                 gate_sense,
    input  wire logic                       temp_warn,
    input  wire logic                       temp_shutdown,
    input  wire logic [2:0]                 open_load_phase_x,
    // gate enables and charge pump
    output logic [5:0]                      fet_enable,
    output logic                            charge_pump_en,
    output logic                            charge_pump_undervoltage,
    // status
    output logic                            fault_out_n,
    output logic                            fault_flag,
    output logic                            sense_overcurrent,
    output logic [2:0]                      sense_oc_phase,
    output logic                            gate_drive_fault,
    output logic [5:0]                      gate_voltage_fault_flag,
    output logic                            thermal_warning,
    output logic                            thermal_shutdown,
    output logic                            open_load_detect,
    output logic                            open_load_or_short_flag,
    output logic [2:0]                      open_load_latched
);
    import gdfr_pkg::*;

    // clear, sleep, threshold and comparator inputs pass two flops; configuration pins do not
    logic [23:0] s1_r, s2_r;
    wire  [23:0] pins = {sleep_reset_pulse, clear_faults, drain_source_threshold_pin,
                         sense_positive_input, gate_cmd, gate_sense, temp_warn,
                         temp_shutdown, open_load_phase_x, 1'b0};
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s1_r <= 24'h0;
            s2_r <= 24'h0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
        end
    end
    wire       sl_rst = s2_r[23];
    wire       clr_in = s2_r[22];
    wire       ds_pin = s2_r[21];
    wire [2:0] sp_in  = s2_r[20:18];
    wire [5:0] g_cmd  = s2_r[17:12];
    wire [5:0] g_sns  = s2_r[11:6];
    wire       t_wrn  = s2_r[5];
    wire       t_sd   = s2_r[4];
    wire [2:0] ol_in  = s2_r[3:1];

    wire clr_any = clr_in | sl_rst;

    // effective overcurrent configuration
    wire [1:0]       oc_mode = hw_variant ? (ds_pin ? OCM_DISABLED : OCM_LATCH)
                                          : overcurrent_response_mode;
    wire [CNT_W-1:0] deg_lim = hw_variant ? DEG_HW_CNT : overcurrent_deglitch_select;
    wire             oc_off  = (oc_mode == OCM_DISABLED);
    // per-bridge disables ignored (locked) while whole monitor is off
    wire [2:0]       sp_mask = oc_off ? 3'h0 : (sp_in & ~sense_monitor_disable_x);

    logic [CNT_W-1:0] deg_r;
    logic [2:0]       deg_ph_r;
    wire              oc_level = |sp_mask;
    wire              oc_event = oc_level && (deg_r >= deg_lim);
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            deg_r    <= '0;
            deg_ph_r <= 3'h0;
        end else begin
            deg_r    <= !oc_level ? '0 : (oc_event ? deg_r : deg_r + 1'b1);
            deg_ph_r <= sp_mask;
        end
    end

    // overcurrent response state
    gdfr_oc_t           oc_st_r, oc_st_nxt;
    logic [RETRY_W-1:0] rty_r;
    logic               oc_flag_r;
    logic [2:0]         oc_ph_r;
    wire rty_done = (rty_r >= retry_interval);
    always_comb begin
        oc_st_nxt = oc_st_r;
        case (oc_st_r)
            GDFR_RUN: begin
                if (oc_event && oc_mode == OCM_RETRY)
                    oc_st_nxt = GDFR_RETRY;
                else if (oc_event && (oc_mode == OCM_LATCH || oc_mode == OCM_REPORT))
                    oc_st_nxt = GDFR_HOLD;
            end
            GDFR_HOLD: begin
                if (clr_any && !oc_level)
                    oc_st_nxt = GDFR_RUN;
            end
            GDFR_RETRY: begin
                if (rty_done)
                    oc_st_nxt = GDFR_RUN;
            end
            default: oc_st_nxt = GDFR_RUN;
        endcase
    end
    logic oc_latch_off_r;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            oc_st_r        <= GDFR_RUN;
            rty_r          <= '0;
            oc_flag_r      <= 1'b0;
            oc_ph_r        <= 3'h0;
            oc_latch_off_r <= 1'b0;
        end else begin
            oc_st_r <= oc_st_nxt;
            rty_r   <= (oc_st_r == GDFR_RETRY) ? rty_r + 1'b1 : '0;
            if (oc_st_r == GDFR_RUN && oc_st_nxt != GDFR_RUN) begin
                oc_flag_r      <= 1'b1;
                oc_ph_r        <= (oc_mode == OCM_RETRY) ? deg_ph_r : 3'h0;
                oc_latch_off_r <= (oc_mode != OCM_REPORT);
            end else if (oc_st_r != GDFR_RUN && oc_st_nxt == GDFR_RUN) begin
                oc_flag_r      <= 1'b0;
                oc_ph_r        <= 3'h0;
                oc_latch_off_r <= 1'b0;
            end
        end
    end
    wire oc_stop = (oc_st_r != GDFR_RUN) && oc_latch_off_r;

    // gate drive monitor, window doubles as blanking
    logic [5:0]       cmd_d_r;
    logic [CNT_W-1:0] win_r [6];
    logic [5:0]       vgs_r;
    logic [5:0]       gdf_now;
    always_comb begin
        // window restarts one edge after a command change, so blank that cycle too
        for (int i = 0; i < 6; i++)
            gdf_now[i] = (win_r[i] >= gate_drive_window) && (g_cmd[i] == cmd_d_r[i]) &&
                         (g_sns[i] != g_cmd[i]);
    end
    wire [5:0] vgs_set = gdf_now & ~vgs_r;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cmd_d_r <= 6'h0;
            vgs_r   <= 6'h0;
            for (int i = 0; i < 6; i++)
                win_r[i] <= '0;
        end else begin
            cmd_d_r <= g_cmd;
            for (int i = 0; i < 6; i++) begin
                if (g_cmd[i] != cmd_d_r[i])
                    win_r[i] <= '0;
                else if (win_r[i] < gate_drive_window)
                    win_r[i] <= win_r[i] + 1'b1;
            end
            // set wins over clear; clear only after condition removed
            vgs_r <= gdf_now | (clr_any ? 6'h0 : vgs_r);
        end
    end
    wire gdf_prot = hw_variant | ~gate_fault_disable;
    wire gdf_rep  = |vgs_r && gdf_prot;

    // shutdown scope by pwm mode
    wire       fet_mode  = (pwm_mode >= 3'(MODE_FET_MIN));
    wire [5:0] gdf_scope;
    genvar p;
    generate
        for (p = 0; p < NPH; p++) begin : g_ph
            // per phase: bridge scope unless fet mode, or half-bridge mode with phase marked independent fet
            wire single = fet_mode || (pwm_mode == MODE_HALF_BR && phase_fet_mode[p]);
            wire bridge = |vgs_r[2*p+1:2*p];
            assign gdf_scope[2*p+1:2*p] = single ? vgs_r[2*p+1:2*p] : {2{bridge}};
        end
    endgenerate
    wire indep = fet_mode || (pwm_mode == MODE_HALF_BR);
    wire [5:0] gdf_off = !gdf_prot ? 6'h0 : (indep ? gdf_scope : {6{|vgs_r}});

    // thermal handling
    wire tsd_mode_eff = hw_variant ? TSD_AUTO : thermal_shutdown_mode;
    logic tsd_flag_r, tsd_off_r, tw_r;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tsd_flag_r <= 1'b0;
            tsd_off_r  <= 1'b0;
            tw_r       <= 1'b0;
        end else begin
            tw_r       <= t_wrn;
            tsd_flag_r <= t_sd | (tsd_flag_r & ~clr_any);
            if (t_sd)
                tsd_off_r <= 1'b1;
            else if (tsd_mode_eff == TSD_AUTO || clr_any)
                tsd_off_r <= 1'b0;
        end
    end
    wire tsd_off = tsd_off_r || (tsd_mode_eff == TSD_LATCHED && tsd_flag_r);

    // open load latch, set wins over clear
    logic [2:0] ol_r;
    logic       ol_off_r;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ol_r     <= 3'h0;
            ol_off_r <= 1'b0;
        end else begin
            ol_r     <= ol_in | (clr_any ? 3'h0 : ol_r);
            ol_off_r <= |(ol_in | (clr_any ? 3'h0 : ol_r));
        end
    end

    // outputs, all registered
    wire fault_any = (oc_st_r != GDFR_RUN) || gdf_rep || tsd_off ||
                     (tw_r && thermal_warning_report && !hw_variant) || (|ol_r);
    wire [5:0] en_nxt = (oc_stop || tsd_off || ol_off_r) ? 6'h0 : ~gdf_off;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fet_enable               <= 6'h0;
            charge_pump_en           <= 1'b0;
            charge_pump_undervoltage <= 1'b0;
            fault_out_n              <= 1'b1;
            fault_flag               <= 1'b0;
            sense_overcurrent        <= 1'b0;
            sense_oc_phase           <= 3'h0;
            gate_drive_fault         <= 1'b0;
            gate_voltage_fault_flag  <= 6'h0;
            thermal_warning          <= 1'b0;
            thermal_shutdown         <= 1'b0;
            open_load_detect         <= 1'b0;
            open_load_or_short_flag  <= 1'b0;
            open_load_latched        <= 3'h0;
        end else begin
            fet_enable               <= en_nxt;
            charge_pump_en           <= !tsd_off;
            charge_pump_undervoltage <= 1'b0;
            fault_out_n              <= !fault_any;
            fault_flag               <= fault_any | (|vgs_r) | tsd_flag_r;
            sense_overcurrent        <= oc_flag_r;
            sense_oc_phase           <= oc_ph_r;
            gate_drive_fault         <= gdf_rep;
            gate_voltage_fault_flag  <= vgs_r;
            thermal_warning          <= tw_r && !hw_variant;
            thermal_shutdown         <= tsd_flag_r;
            open_load_detect         <= |ol_r;
            open_load_or_short_flag  <= |ol_r;
            open_load_latched        <= ol_r;
        end
    end

    // checks
    chk_tsd_stops_fets: assert property (@(posedge mclk) disable iff (!resetn)
        t_sd |-> ##1 1'b1 ##1 (fet_enable == 6'h0 && !charge_pump_en && !fault_out_n))
        else $error("thermal shutdown did not stop drive");
    chk_oc_hold_release: assert property (@(posedge mclk) disable iff (!resetn)
        (oc_st_r == GDFR_HOLD && !clr_any) |=> oc_st_r == GDFR_HOLD)
        else $error("overcurrent hold left without clear");
    chk_retry_recovers: assert property (@(posedge mclk) disable iff (!resetn)
        (oc_st_r == GDFR_RETRY && rty_done) |=> (oc_st_r == GDFR_RUN && !oc_flag_r))
        else $error("retry did not recover");
    chk_report_runs: assert property (@(posedge mclk) disable iff (!resetn)
        (oc_st_r != GDFR_RUN && !oc_latch_off_r && !tsd_off && !ol_off_r && !(|gdf_off))
        |=> fet_enable == 6'h3f)
        else $error("report mode stopped drivers");
    chk_disabled_quiet: assert property (@(posedge mclk) disable iff (!resetn)
        (oc_mode == OCM_DISABLED && oc_st_r == GDFR_RUN) |=> oc_st_r == GDFR_RUN)
        else $error("disabled monitor acted");
    chk_deglitch_wait: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(oc_level) |-> !oc_event)
        else $error("overcurrent without deglitch");
    chk_gdf_latched: assert property (@(posedge mclk) disable iff (!resetn)
        (|vgs_set) |=> (|vgs_r) ##1 (!gdf_prot || !fault_out_n))
        else $error("gate fault not reported");
    chk_gdf_disable_run: assert property (@(posedge mclk) disable iff (!resetn)
        (!gdf_prot && !oc_stop && !tsd_off && !ol_off_r) |=> fet_enable == 6'h3f)
        else $error("gate fault disable still stopped fets");
    chk_ol_release: assert property (@(posedge mclk) disable iff (!resetn)
        ((|ol_r) && !clr_any) |=> (|ol_r))
        else $error("open load latch dropped");
    chk_oc_stops_fets: assert property (@(posedge mclk) disable iff (!resetn)
        oc_stop |=> fet_enable == 6'h00)
        else $error("overcurrent shutdown left fets on");
    chk_gdf_blanked: assert property (@(posedge mclk) disable iff (!resetn)
        !(|((g_cmd ^ cmd_d_r) & gdf_now)))
        else $error("gate fault seen inside blanking");
    chk_tw_reported: assert property (@(posedge mclk) disable iff (!resetn)
        (tw_r && thermal_warning_report && !hw_variant) |=> !fault_out_n)
        else $error("reported thermal warning not on fault pin");
    chk_tsd_cp_off: assert property (@(posedge mclk) disable iff (!resetn)
        tsd_off |=> (!charge_pump_en && !charge_pump_undervoltage))
        else $error("charge pump not stopped cleanly in shutdown");
    chk_tsd_auto_resume: assert property (@(posedge mclk) disable iff (!resetn)
        (tsd_mode_eff == TSD_AUTO && tsd_off_r && !t_sd) |=> !tsd_off_r)
        else $error("auto thermal recovery did not resume");
    chk_ol_stops_fets: assert property (@(posedge mclk) disable iff (!resetn)
        ol_off_r |=> fet_enable == 6'h00)
        else $error("open load did not stop fets");
    chk_fault_pin_or: assert property (@(posedge mclk) disable iff (!resetn)
        1'b1 |=> fault_out_n == !$past(fault_any))
        else $error("fault pin does not follow fault sources");
    cov_report_only: cover property (@(posedge mclk) oc_st_r == GDFR_HOLD && !oc_latch_off_r);
    cov_oc_latch: cover property (@(posedge mclk) oc_st_r == GDFR_HOLD && oc_latch_off_r);
    cov_oc_retry: cover property (@(posedge mclk) oc_st_r == GDFR_RETRY ##1 oc_st_r == GDFR_RUN);
    cov_gdf_bridge: cover property (@(posedge mclk) indep && (|gdf_off) && !(&gdf_off));
    cov_tsd_auto: cover property (@(posedge mclk) $fell(tsd_off_r) && tsd_flag_r);
endmodule

/* File: testbench/gdfr_gate_model.sv */
// far-side gate model: sensed gate levels follow the enabled commands
`timescale 1ns/1ps
module gdfr_gate_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // commands from the block side
    input  wire logic [5:0] gate_cmd,
    input  wire logic [5:0] fet_enable,
    input  wire logic [5:0] stuck_low,
    // sensed gate levels
    output logic [5:0]      gate_sense
);
    logic [5:0] lag1_r;
    logic [5:0] lag2_r;
    // two-cycle lag stands in for the gate slew; a stuck gate never rises
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            lag1_r <= 6'h00;
            lag2_r <= 6'h00;
        end else begin
            lag1_r <= gate_cmd & fet_enable & ~stuck_low;
            lag2_r <= lag1_r;
        end
    end
    assign gate_sense = lag2_r;
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the gate driver fault response block
`timescale 1ns/1ps
module tb_top;
    import gdfr_pkg::*;
    typedef struct {int sel; logic [7:0] exp;} gdfr_note_t;
    localparam int DEG = 8;
    localparam int WIN = 10;
    localparam int RTY = 10;
    logic mclk, resetn, hw_variant, drain_source_threshold_pin, gate_fault_disable;
    logic thermal_warning_report, thermal_shutdown_mode, clear_faults, sleep_reset_pulse;
    logic temp_warn, temp_shutdown, charge_pump_en, charge_pump_undervoltage, fault_out_n;
    logic fault_flag, sense_overcurrent, gate_drive_fault, thermal_warning, thermal_shutdown;
    logic open_load_detect, open_load_or_short_flag;
    logic [1:0] overcurrent_response_mode;
    logic [2:0] pwm_mode, phase_fet_mode, sense_monitor_disable_x, sense_positive_input;
    logic [2:0] open_load_phase_x, sense_oc_phase, open_load_latched;
    logic [5:0] gate_cmd, gate_sense, fet_enable, gate_voltage_fault_flag, stuck_low;
    logic [2:0] gpm[5] = '{3'h0, 3'h3, 3'h3, 3'h7, 3'h0};
    logic [2:0] gpf[5] = '{3'h0, 3'h0, 3'h2, 3'h0, 3'h0};
    logic [7:0] gex[5] = '{8'h00, 8'h33, 8'h37, 8'h37, 8'h3f};
    gdfr_note_t q[$];
    gdfr_note_t nt;
    int n_mismatch, n_compared, cycles, seed;
    string nm[14] = '{"fault_out_n", "fet_enable", "sense_overcurrent", "sense_oc_phase",
        "gate_drive_fault", "gate_voltage_fault_flag", "thermal_warning", "thermal_shutdown",
        "charge_pump_en", "charge_pump_undervoltage", "open_load_detect",
        "open_load_latched", "fault_flag", "open_load_or_short_flag"};

    gdfr_top dut (
        .mclk, .resetn, .hw_variant, .drain_source_threshold_pin, .overcurrent_response_mode,
        .overcurrent_deglitch_select(CNT_W'(DEG)), .retry_interval(RETRY_W'(RTY)),
        .gate_drive_window(CNT_W'(WIN)), .pwm_mode, .phase_fet_mode, .sense_monitor_disable_x,
        .gate_fault_disable, .thermal_warning_report, .thermal_shutdown_mode, .clear_faults,
        .sleep_reset_pulse, .sense_positive_input, .gate_cmd, .gate_sense, .temp_warn,
        .temp_shutdown, .open_load_phase_x, .fet_enable, .charge_pump_en,
        .charge_pump_undervoltage, .fault_out_n, .fault_flag, .sense_overcurrent,
        .sense_oc_phase, .gate_drive_fault, .gate_voltage_fault_flag, .thermal_warning,
        .thermal_shutdown, .open_load_detect, .open_load_or_short_flag, .open_load_latched
    );
    gdfr_gate_model gates (
        .mclk(mclk), .resetn(resetn), .gate_cmd(gate_cmd), .fet_enable(fet_enable),
        .stuck_low(stuck_low), .gate_sense(gate_sense)
    );

    function automatic logic [7:0] obs(input int s);
        case (s)
            0: obs = {7'h0, fault_out_n};
            1: obs = {2'h0, fet_enable};
            2: obs = {7'h0, sense_overcurrent};
            3: obs = {5'h0, sense_oc_phase};
            4: obs = {7'h0, gate_drive_fault};
            5: obs = {2'h0, gate_voltage_fault_flag};
            6: obs = {7'h0, thermal_warning};
            7: obs = {7'h0, thermal_shutdown};
            8: obs = {7'h0, charge_pump_en};
            9: obs = {7'h0, charge_pump_undervoltage};
            10: obs = {7'h0, open_load_detect};
            11: obs = {5'h0, open_load_latched};
            13: obs = {7'h0, open_load_or_short_flag};
            default: obs = {7'h0, fault_flag};
        endcase
    endfunction
    task automatic chk(input int s, input logic [7:0] e);
        q.push_back('{s, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic clr_pulse(input bit via_sleep);
        @(posedge mclk);
        clear_faults <= !via_sleep;
        sleep_reset_pulse <= via_sleep;
        cyc(3);
        clear_faults <= 1'b0;
        sleep_reset_pulse <= 1'b0;
        cyc(6);
    endtask
    task automatic wrap_up();
        cyc(2);
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // notes are judged half a cycle later, once the edge's updates have landed
    always @(negedge mclk) begin
        while (q.size() > 0) begin
            nt = q.pop_front();
            n_compared++;
            if (obs(nt.sel) !== nt.exp) begin
                $display("[FAIL] %s expected %h seen %h", nm[nt.sel], nt.exp, obs(nt.sel));
                n_mismatch++;
            end
        end
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        {resetn, hw_variant, drain_source_threshold_pin, gate_fault_disable} = 4'h0;
        {thermal_warning_report, thermal_shutdown_mode, clear_faults} = 3'h0;
        {sleep_reset_pulse, temp_warn, temp_shutdown} = 3'h0;
        overcurrent_response_mode = 2'h0;
        {pwm_mode, phase_fet_mode, sense_monitor_disable_x} = 9'h000;
        {sense_positive_input, open_load_phase_x} = 6'h00;
        {gate_cmd, stuck_low} = 12'h000;
        seed = 19199;
        cyc(6);
        resetn <= 1'b1;
        cyc(3);
        chk(1, 8'h3f); chk(0, 8'h01); chk(8, 8'h01); chk(12, 8'h00);
        $display("test reset finished");
        for (int m = 0; m < 4; m++) begin
            overcurrent_response_mode <= 2'(m);
            sense_positive_input <= 3'h2;
            cyc(DEG - 3);
            sense_positive_input <= 3'h0;
            cyc(6);
            chk(0, 8'h01); chk(2, 8'h00);
            sense_positive_input <= 3'h2;
            cyc(DEG + 6);
            chk(1, (m < 2) ? 8'h00 : 8'h3f);
            chk(0, (m == 3) ? 8'h01 : 8'h00);
            chk(2, (m == 3) ? 8'h00 : 8'h01);
            if (m == 1) begin
                chk(3, 8'h02);
                sense_positive_input <= 3'h0;
                cyc(RTY + 6);
            end else begin
                clr_pulse(1'b0);
                chk(0, (m == 3) ? 8'h01 : 8'h00);
                sense_positive_input <= 3'h0;
                cyc(3);
                clr_pulse(1'b0);
            end
            chk(1, 8'h3f); chk(0, 8'h01); chk(2, 8'h00);
        end
        $display("test overcurrent modes finished");
        overcurrent_response_mode <= 2'h0;
        sense_monitor_disable_x <= 3'h2;
        sense_positive_input <= 3'h2;
        cyc(DEG + 6);
        chk(1, 8'h3f); chk(0, 8'h01); chk(2, 8'h00);
        sense_positive_input <= 3'h0;
        cyc(4);
        sense_monitor_disable_x <= 3'h0;
        hw_variant <= 1'b1;
        overcurrent_response_mode <= 2'h2;
        sense_positive_input <= 3'h1;
        cyc(30);
        chk(0, 8'h01);
        cyc(30);
        chk(1, 8'h00); chk(0, 8'h00);
        sense_positive_input <= 3'h0;
        clr_pulse(1'b0);
        drain_source_threshold_pin <= 1'b1;
        cyc(3);
        sense_positive_input <= 3'h1;
        cyc(60);
        chk(1, 8'h3f); chk(0, 8'h01);
        sense_positive_input <= 3'h0;
        {hw_variant, drain_source_threshold_pin} <= 2'h0;
        overcurrent_response_mode <= 2'h0;
        cyc(4);
        $display("test hardware variant finished");
        for (int i = 0; i < 5; i++) begin
            pwm_mode <= gpm[i];
            phase_fet_mode <= gpf[i];
            gate_fault_disable <= (i == 4);
            stuck_low <= 6'h08;
            cyc(3);
            gate_cmd <= 6'h08;
            cyc(WIN - 4);
            chk(5, 8'h00);
            cyc(14);
            chk(5, 8'h08); chk(1, gex[i]);
            if (i < 4) begin
                chk(4, 8'h01); chk(0, 8'h00); chk(12, 8'h01);
            end else begin
                chk(4, 8'h00); chk(0, 8'h01);
            end
            gate_cmd <= 6'h00;
            stuck_low <= 6'h00;
            cyc(4);
            clr_pulse(1'b0);
            chk(4, 8'h00); chk(5, 8'h00); chk(1, 8'h3f); chk(0, 8'h01);
        end
        gate_fault_disable <= 1'b0;
        pwm_mode <= 3'h0;
        $display("test gate faults finished");
        temp_warn <= 1'b1;
        cyc(5);
        chk(6, 8'h01); chk(0, 8'h01); chk(1, 8'h3f);
        thermal_warning_report <= 1'b1;
        cyc(4);
        chk(0, 8'h00);
        temp_warn <= 1'b0;
        cyc(5);
        chk(6, 8'h00); chk(0, 8'h01);
        for (int k = 0; k < 2; k++) begin
            thermal_shutdown_mode <= k[0];
            temp_shutdown <= 1'b1;
            cyc(6);
            chk(1, 8'h00); chk(8, 8'h00); chk(9, 8'h00); chk(0, 8'h00);
            chk(7, 8'h01); chk(12, 8'h01);
            temp_shutdown <= 1'b0;
            cyc(6);
            chk(1, (k == 1) ? 8'h3f : 8'h00); chk(7, 8'h01);
            chk(0, (k == 1) ? 8'h01 : 8'h00);
            clr_pulse(k == 0);
            chk(1, 8'h3f); chk(8, 8'h01); chk(7, 8'h00); chk(0, 8'h01);
        end
        $display("test thermal finished");
        open_load_phase_x <= 3'h2;
        temp_warn <= 1'b1;
        cyc(5);
        chk(0, 8'h00); chk(10, 8'h01); chk(11, 8'h02); chk(13, 8'h01);
        clr_pulse(1'b0);
        chk(10, 8'h01);
        open_load_phase_x <= 3'h0;
        cyc(3);
        clr_pulse(1'b0);
        chk(10, 8'h00); chk(11, 8'h00); chk(13, 8'h00); chk(0, 8'h00);
        temp_warn <= 1'b0;
        cyc(5);
        chk(0, 8'h01);
        $display("test open load finished");
        repeat (20) begin
            gate_cmd <= 6'($random(seed));
            cyc(WIN + 6);
            chk(4, 8'h00); chk(1, 8'h3f);
        end
        $display("test random gates finished");
        wrap_up();
    end
endmodule
